/* File: hw/lbd_regs.svh */
// Purpose: register offsets, reset values and counter limits of the bypass dimmer
// Assumes: byte-wide register addresses, one 13-bit word per address
// Notes:   definitions only
`ifndef LBD_REGS_SVH
`define LBD_REGS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define LBD_ADDR_W        8
`define LBD_ADDR_CH8      8'h2c
`define LBD_ADDR_CH9      8'h2d
`define LBD_ADDR_CH10     8'h2e
`define LBD_ADDR_CH11     8'h2f
`define LBD_CHAN_CNT      3
`define LBD_CTRL_RESET    13'h0000
`define LBD_DIM_OFF_BIT   12

// ----------------------------------------------------------------------------
// period counter
// ----------------------------------------------------------------------------
`define LBD_CNT_FIRST     12'h000
`define LBD_CNT_LAST      12'hffe
`define LBD_CNT_STEP      12'h001
`define LBD_CODE_OFF      12'h000
`define LBD_CODE_MIN      12'h001
`define LBD_CODE_FULL     12'hfff
`define LBD_RDATA_IDLE    13'h0000

`endif

/* File: hw/lbd_pkg.sv */
// Purpose: types shared by the bypass dimmer
// Assumes: three channels, 13-bit control words
// Notes:   constants live in lbd_regs.svh
package lbd_pkg;

  // one channel control word: bit 12 high stops dimming, bits 11:0 the on code
  typedef struct packed {
    logic        dim_off;
    logic [11:0] on_code;
  } lbd_ctrl_t;

  // register access request from the serial host port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [12:0] wdata;
  } lbd_req_t;

  // read answer
  typedef struct packed {
    logic        valid;
    logic [12:0] data;
  } lbd_rsp_t;

  // whole state of the dimmer
  typedef struct packed {
    logic [11:0]       cnt;
    lbd_ctrl_t [2:0]   ctrl;
    lbd_rsp_t          rsp;
    logic [2:0]        sw_on;
  } lbd_state_t;

endpackage : lbd_pkg

/* File: hw/lbd_dimmer.sv */
// Purpose: dimming control words and switch drive for bypass channels 9 to 11
// Assumes: register port driven by logic on clk_sys, one request per cycle at most
// Notes:   index 0 is channel 9, 1 is channel 10, 2 is channel 11
//          the serial host port sits outside; this block sees a parallel request
//          a read answers one cycle after it is taken, then drops back to zero
//          a write and a read in one cycle: the read returns the old word
//          unmapped writes are dropped and unmapped reads answer with zero
//          codes act at once, with no shadowing to the period boundary
//          the period counter runs 0 to 4094, so a period lasts 4095 cycles
//          limitation: the counter is free running and cannot be synchronised
//
// Behaviour
// - 12-bit on code: zero keeps switch off, all ones keeps it on.
// - each code step adds one 1/4095 slice of the period.
// - channel 9 bit 12 low enables dimming, high disables it.
// - channel 10 bit 12 low enables dimming, high disables it.
// - channel 11 bit 12 low enables dimming, high disables it.
// - word at 0x2d controls channel 9, writable and readable.
// - word at 0x2e controls channel 10, reads return stored contents.
// - word at 0x2f controls channel 11, writable and readable.
// - words use stride one; 0x2c belongs to channel 8, outside here.
`include "lbd_regs.svh"
`timescale 1ns/100ps

module lbd_dimmer (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire lbd_pkg::lbd_req_t reg_req,
  output lbd_pkg::lbd_rsp_t      reg_rsp,
  output logic                   bypass_channel_9,
  output logic                   bypass_channel_10,
  output logic                   bypass_channel_11
);

  lbd_pkg::lbd_state_t st_q;
  lbd_pkg::lbd_state_t st_d;

  // ----------------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------------
  // hit flag and channel index; shared by the write and read paths
  function automatic logic [2:0] chan_decode(input logic [7:0] addr);
    logic [7:0] ofs;
    ofs = addr - `LBD_ADDR_CH9;
    if (ofs < 8'(`LBD_CHAN_CNT)) begin
      chan_decode = {1'b1, ofs[1:0]};
    end else begin
      chan_decode = 3'h0;
    end
  endfunction : chan_decode

  logic [2:0] wr_hit;
  logic [2:0] rd_hit;

  assign wr_hit = chan_decode(reg_req.addr);
  assign rd_hit = chan_decode(reg_req.addr);

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  // counter runs 0..4094 so code 0xfff is never reached and stays on for good
  always_comb begin
    st_d = st_q;
    if (st_q.cnt == `LBD_CNT_LAST) begin
      st_d.cnt = `LBD_CNT_FIRST;
    end else begin
      st_d.cnt = st_q.cnt + `LBD_CNT_STEP;
    end
    // register writes; unmapped addresses are ignored
    if (reg_req.wr && wr_hit[2]) begin
      st_d.ctrl[wr_hit[1:0]] = reg_req.wdata;
    end
    // read answer one cycle later; unmapped reads return zero
    st_d.rsp.valid = reg_req.rd;
    st_d.rsp.data  = `LBD_RDATA_IDLE;
    if (reg_req.rd && rd_hit[2]) begin
      st_d.rsp.data = st_q.ctrl[rd_hit[1:0]];
    end
    // compare against the live code; a new code takes hold at once, so a
    // period in which it changes may be cut short or stretched once
    for (int i = 0; i < `LBD_CHAN_CNT; i++) begin
      st_d.sw_on[i] = !st_q.ctrl[i].dim_off && (st_q.cnt < st_q.ctrl[i].on_code);
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q.cnt   <= `LBD_CNT_FIRST;
      st_q.ctrl  <= {`LBD_CHAN_CNT{`LBD_CTRL_RESET}};
      st_q.rsp   <= {1'b0, `LBD_RDATA_IDLE};
      st_q.sw_on <= 3'h0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign reg_rsp           = st_q.rsp;
  assign bypass_channel_9  = st_q.sw_on[0];
  assign bypass_channel_10 = st_q.sw_on[1];
  assign bypass_channel_11 = st_q.sw_on[2];

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // per channel: zero code never drives, full code with dimming on always drives
  for (genvar k = 0; k < `LBD_CHAN_CNT; k++) begin : g_chk
    a_zero_code_off: assert property (
      $past(st_q.ctrl[k].on_code) == `LBD_CODE_OFF |-> !st_q.sw_on[k])
      else $error("switch on with zero code");
    a_full_code_on: assert property (
      $past(st_q.ctrl[k]) == {1'b0, `LBD_CODE_FULL} |-> st_q.sw_on[k])
      else $error("switch off with full code");
    a_step_edge: assert property (
      ($past(st_q.ctrl[k]) == $past(st_q.ctrl[k], 2)) && !$past(st_q.ctrl[k].dim_off)
      && $past(st_q.cnt) == $past(st_q.ctrl[k].on_code) && $past(st_q.ctrl[k].on_code) != '0
      |-> $fell(st_q.sw_on[k]))
      else $error("on time does not end at the code count");
  end

  a_cnt_wrap: assert property (
    st_q.cnt == `LBD_CNT_LAST |=> st_q.cnt == `LBD_CNT_FIRST ##1 st_q.cnt == `LBD_CNT_STEP)
    else $error("period counter does not wrap after 4095 counts");
  a_ch9_disable: assert property (
    $past(st_q.ctrl[0].dim_off) |-> !bypass_channel_9)
    else $error("channel 9 drives while dimming disabled");
  a_ch10_disable: assert property (
    $past(st_q.ctrl[1].dim_off) |-> !bypass_channel_10)
    else $error("channel 10 drives while dimming disabled");
  a_ch11_disable: assert property (
    $past(st_q.ctrl[2].dim_off) |-> !bypass_channel_11)
    else $error("channel 11 drives while dimming disabled");
  a_ch9_write: assert property (
    reg_req.wr && reg_req.addr == `LBD_ADDR_CH9 |=> st_q.ctrl[0] == $past(reg_req.wdata))
    else $error("channel 9 word not written");
  a_ch10_read: assert property (
    reg_req.rd && reg_req.addr == `LBD_ADDR_CH10
    |=> reg_rsp.valid && reg_rsp.data == $past(st_q.ctrl[1]))
    else $error("channel 10 word read back wrong");
  a_ch11_write: assert property (
    reg_req.wr && reg_req.addr == `LBD_ADDR_CH11 ##1 reg_req.rd && reg_req.addr == `LBD_ADDR_CH11
    |=> reg_rsp.data == $past(reg_req.wdata, 2))
    else $error("channel 11 word not read back");
  a_ch8_ignored: assert property (
    reg_req.wr && reg_req.addr == `LBD_ADDR_CH8 |=> $stable(st_q.ctrl))
    else $error("write to channel 8 offset changed a word here");

  // ----------------------------------------------------------------------------
  // register port, decode and counter range
  // ----------------------------------------------------------------------------
  // the answer is a one-cycle pulse; a stale valid would let the host take a
  // word twice, so check that it drops and that the data returns to idle
  a_rsp_pulse: assert property (
    !reg_req.rd |=> !reg_rsp.valid && reg_rsp.data == `LBD_RDATA_IDLE)
    else $error("read answer stands without a read");
  a_ch9_read: assert property (
    reg_req.rd && reg_req.addr == `LBD_ADDR_CH9
    |=> reg_rsp.valid && reg_rsp.data == $past(st_q.ctrl[0]))
    else $error("channel 9 word read back wrong");
  a_ch10_write: assert property (
    reg_req.wr && reg_req.addr == `LBD_ADDR_CH10 |=> st_q.ctrl[1] == $past(reg_req.wdata))
    else $error("channel 10 word not written");
  a_ch11_store: assert property (
    reg_req.wr && reg_req.addr == `LBD_ADDR_CH11 |=> st_q.ctrl[2] == $past(reg_req.wdata))
    else $error("channel 11 word not stored");
  a_ch11_read: assert property (
    reg_req.rd && reg_req.addr == `LBD_ADDR_CH11
    |=> reg_rsp.valid && reg_rsp.data == $past(st_q.ctrl[2]))
    else $error("channel 11 word read back wrong");

  // unmapped offsets must neither answer with a stored word nor disturb one
  a_ch8_read_zero: assert property (
    reg_req.rd && reg_req.addr == `LBD_ADDR_CH8
    |=> reg_rsp.valid && reg_rsp.data == `LBD_RDATA_IDLE)
    else $error("read of channel 8 offset returned data");
  a_unmapped_write: assert property (
    reg_req.wr && !wr_hit[2] |=> $stable(st_q.ctrl))
    else $error("unmapped write changed a word here");
  a_hit_range: assert property (
    wr_hit[2] |-> wr_hit[1:0] < 2'(`LBD_CHAN_CNT))
    else $error("decode hit outside the three channels");

  // the counter must never reach the full code, else full scale would blink
  a_cnt_range: assert property (
    st_q.cnt <= `LBD_CNT_LAST)
    else $error("period counter beyond its last count");
  a_cnt_step: assert property (
    st_q.cnt != `LBD_CNT_LAST |=> st_q.cnt == $past(st_q.cnt) + `LBD_CNT_STEP)
    else $error("period counter skipped a count");

  // back-to-back write then read of one word, which the host may issue
  c_ch11_b2b: cover property (
    reg_req.wr && reg_req.addr == `LBD_ADDR_CH11 ##1 reg_req.rd && reg_req.addr == `LBD_ADDR_CH11);

  c_ch9_dims: cover property (st_q.ctrl[0].on_code == `LBD_CODE_MIN ##1 $rose(bypass_channel_9));
  c_ch10_off: cover property (st_q.ctrl[1].dim_off ##1 !bypass_channel_10);
  c_ch11_read: cover property (reg_req.rd && reg_req.addr == `LBD_ADDR_CH11);
  c_wrap: cover property (st_q.cnt == `LBD_CNT_LAST);

endmodule : lbd_dimmer

/* File: testbench/lbd_dimmer_tb_top.sv */
// Purpose: self-checking bench for the bypass dimmer, channels 9 to 11
// Assumes: parallel register port; tasks leave one idle cycle between requests, except wr_rd between its write and read
// Notes:   each duty window spans exactly one 4095-cycle period
`include "lbd_regs.svh"
`timescale 1ns/100ps

module lbd_dimmer_tb_top;
  logic              clk_sys;
  logic              reset_n;
  lbd_pkg::lbd_req_t reg_req;
  lbd_pkg::lbd_rsp_t reg_rsp;
  logic              bypass_channel_9;
  logic              bypass_channel_10;
  logic              bypass_channel_11;
  int                failures = 0;
  int                checks = 0;

  lbd_dimmer dut (
    .clk_sys           (clk_sys),
    .reset_n           (reset_n),
    .reg_req           (reg_req),
    .reg_rsp           (reg_rsp),
    .bypass_channel_9  (bypass_channel_9),
    .bypass_channel_10 (bypass_channel_10),
    .bypass_channel_11 (bypass_channel_11)
  );

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // on cycles per period: disabled dimming keeps the switch off
  function automatic logic [12:0] on_cnt(input logic [12:0] w);
    return w[12] ? 13'h0000 : {1'b0, w[11:0]};
  endfunction : on_cnt

  task automatic wr(input logic [7:0] a, input logic [12:0] d);
    @(posedge clk_sys) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys) reg_req <= '0;
  endtask : wr

  // answer lands one edge after the request is taken
  task automatic rd(input logic [7:0] a, input logic [12:0] exp);
    @(posedge clk_sys) reg_req <= '{1'b0, 1'b1, a, 13'h0000};
    @(posedge clk_sys) reg_req <= '0;
    #1;
    cmp({12'h000, reg_rsp.valid}, 13'h0001);
    cmp(reg_rsp.data, exp);
  endtask : rd

  // write then read the same word in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [12:0] d);
    @(posedge clk_sys) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys) reg_req <= '{1'b0, 1'b1, a, 13'h0000};
    @(posedge clk_sys) reg_req <= '0;
    #1;
    cmp(reg_rsp.data, d);
  endtask : wr_rd

  // count on cycles over one whole period; any 4095-cycle window works
  task automatic duty(input logic [12:0] w9, input logic [12:0] w10, input logic [12:0] w11);
    int n9;
    int n10;
    int n11;
    n9 = 0;
    n10 = 0;
    n11 = 0;
    wr(`LBD_ADDR_CH9, w9);
    wr(`LBD_ADDR_CH10, w10);
    wr(`LBD_ADDR_CH11, w11);
    repeat (2) @(posedge clk_sys);
    repeat (4095) begin
      @(posedge clk_sys) #1;
      n9 += int'(bypass_channel_9 === 1'b1);
      n10 += int'(bypass_channel_10 === 1'b1);
      n11 += int'(bypass_channel_11 === 1'b1);
    end
    cmp(13'(n9), on_cnt(w9));
    cmp(13'(n10), on_cnt(w10));
    cmp(13'(n11), on_cnt(w11));
  endtask : duty

  task automatic complete_run();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // --------------------------------------------------------------------------
  // clock, watchdog, main sequence
  // --------------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // about four times the expected run of some 12500 cycles
  initial begin
    #500000;
    failures++;
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    reg_req = '0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    cmp({10'h000, bypass_channel_9, bypass_channel_10, bypass_channel_11}, 13'h0000);
    rd(`LBD_ADDR_CH9, `LBD_CTRL_RESET);
    rd(`LBD_ADDR_CH10, `LBD_CTRL_RESET);
    rd(`LBD_ADDR_CH11, `LBD_CTRL_RESET);
    wr(`LBD_ADDR_CH9, 13'h1abc);
    wr(`LBD_ADDR_CH10, 13'h0123);
    wr(`LBD_ADDR_CH11, 13'h1fff);
    wr(`LBD_ADDR_CH8, 13'h0555);
    rd(`LBD_ADDR_CH9, 13'h1abc);
    rd(`LBD_ADDR_CH10, 13'h0123);
    rd(`LBD_ADDR_CH11, 13'h1fff);
    rd(`LBD_ADDR_CH8, 13'h0000);
    wr_rd(`LBD_ADDR_CH11, 13'h1fff);
    duty(13'h0001, 13'h0800, 13'h0fff);
    duty(13'h1fff, 13'h0000, 13'h0ffe);
    duty(13'h0002, 13'h1fff, 13'h1001);
    // second reset in mid-run must clear the stored words
    @(posedge clk_sys) reset_n <= 1'b0;
    @(posedge clk_sys) #1;
    cmp({10'h000, bypass_channel_9, bypass_channel_10, bypass_channel_11}, 13'h0000);
    @(posedge clk_sys) reset_n <= 1'b1;
    rd(`LBD_ADDR_CH10, `LBD_CTRL_RESET);
    complete_run();
  end
endmodule : lbd_dimmer_tb_top
